/* rtl/psc_store_cond_pair.sv */
// Execution unit for the conditional paired-word store instructions
`timescale 1ns/1ps
module psc_store_cond_pair
    import psc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [psc_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [psc_pkg::WORD_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [psc_pkg::WORD_W-1:0] reg_rdata,
    input wire logic issue_valid,
    input wire logic issue_user_space,
    input wire logic [psc_pkg::ADDR_W-1:0] issue_base_addr,
    input wire logic [psc_pkg::WORD_W-1:0] issue_low_word_source_data,
    input wire logic [psc_pkg::WORD_W-1:0] issue_rd_data,
    output logic issue_ready,
    input wire logic cop0_usable,
    input wire logic ll_valid,
    input wire logic [psc_pkg::ADDR_W-1:0] ll_paddr,
    input wire logic snoop_store_valid,
    input wire logic [psc_pkg::ADDR_W-1:0] snoop_paddr,
    input wire logic eret_exec,
    input wire logic exc_taken,
    output logic xlat_req,
    output logic [psc_pkg::ADDR_W-1:0] xlat_vaddr,
    output logic xlat_user_map,
    input wire logic xlat_ack,
    input wire logic [psc_pkg::ADDR_W-1:0] xlat_paddr,
    input wire logic xlat_cached,
    input wire psc_pkg::psc_fault_t xlat_fault,
    input wire psc_pkg::psc_seg_mode_t xlat_seg_mode,
    input wire logic watch_hit,
    output logic mem_req,
    output logic mem_lock,
    output logic [psc_pkg::ADDR_W-1:0] mem_addr,
    output logic [psc_pkg::WORD_W-1:0] mem_wdata,
    input wire logic mem_ack,
    output logic wb_valid,
    output logic [psc_pkg::WORD_W-1:0] wb_result,
    output logic exc_valid,
    output psc_pkg::psc_exc_t exc_code
);
    import psc_pkg::*;

    typedef struct packed {
        psc_state_t state;
        logic user_space;
        logic [ADDR_W-1:0] vaddr;
        logic [ADDR_W-1:0] paddr;
        logic [WORD_W-1:0] lo_word;
        logic [WORD_W-1:0] hi_word;
        logic [CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0] succ_cnt;
        logic [CNT_W-1:0] fail_cnt;
        logic last_ok;
        logic last_exc;
        logic [WORD_W-1:0] rdata;
        logic issue_ready;
        logic xlat_req;
        logic mem_req;
        logic mem_lock;
        logic [ADDR_W-1:0] mem_addr;
        logic [WORD_W-1:0] mem_wdata;
        logic wb_valid;
        logic [WORD_W-1:0] wb_result;
        logic exc_valid;
        psc_exc_t exc_code;
    } psc_top_state_t;

    psc_top_state_t st_reg;
    psc_top_state_t st_next;
    logic sc_done;
    logic link_ok;
    logic link_flag;
    logic [ADDR_W-1:0] linked_address;
    logic addr_match;
    logic target_ok;
    logic seg_ok;
    logic [STATUS_W-1:0] status_bits;

    psc_link_monitor u_link_monitor (
        .clk(clk),
        .reset_n(reset_n),
        .ll_valid(ll_valid),
        .ll_paddr(ll_paddr),
        .snoop_store_valid(snoop_store_valid),
        .snoop_paddr(snoop_paddr),
        .eret_exec(eret_exec),
        .exc_taken(exc_taken),
        .sc_done(sc_done),
        .link_flag(link_flag),
        .linked_address(linked_address)
    );

    // Idle, ready for issue, control bits at their reset value
    localparam psc_top_state_t ST_RESET = '{
        state: st_idle,
        ctrl: CTRL_RESET,
        issue_ready: 1'b1,
        exc_code: exc_none,
        default: '0
    };

    // Compare at double-word granularity, whatever the low bits hold
    assign addr_match = xlat_paddr[ADDR_W-1:DW_LSB] ==
        linked_address[ADDR_W-1:DW_LSB];
    // Uncached targets only when configured; otherwise the store fails
    assign target_ok = xlat_cached || st_reg.ctrl[CTRL_ULS] ||
        st_reg.ctrl[CTRL_NOCACHE];
    // Kernel variant may use any segment
    assign seg_ok = !st_reg.user_space ||
        xlat_seg_mode == mapped_user_super_kernel_mode ||
        xlat_seg_mode == unmapped_user_super_kernel_mode ||
        xlat_seg_mode == mapped_user_super_kernel_alt_mode;

    // Link state, address and target cacheability decide; local loads never reach here
    assign link_ok = link_flag && addr_match && target_ok;

    // Busy covers translation and both word writes
    always_comb begin
        status_bits = '0;
        status_bits[ST_LINK] = link_flag;
        status_bits[ST_LAST_OK] = st_reg.last_ok;
        status_bits[ST_BUSY] = st_reg.state != st_idle;
        status_bits[ST_LAST_EXC] = st_reg.last_exc;
    end

    always_comb begin
        st_next = st_reg;
        sc_done = 1'b0;
        st_next.wb_valid = 1'b0;
        st_next.exc_valid = 1'b0;
        // Read data stands one cycle only, zero otherwise
        st_next.rdata = '0;

        if (reg_wr && reg_addr == REG_CTRL) begin
            st_next.ctrl = reg_wdata[CTRL_W-1:0];
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: st_next.rdata = {{(WORD_W-CTRL_W){1'b0}},
                    st_reg.ctrl};
                REG_STATUS: st_next.rdata = {{(WORD_W-STATUS_W){1'b0}},
                    status_bits};
                REG_LINKED_ADDR: st_next.rdata = linked_address;
                REG_SUCC_CNT: st_next.rdata = {{(WORD_W-CNT_W){1'b0}},
                    st_reg.succ_cnt};
                REG_FAIL_CNT: st_next.rdata = {{(WORD_W-CNT_W){1'b0}},
                    st_reg.fail_cnt};
                default: st_next.rdata = '0;
            endcase
        end

        case (st_reg.state)
            st_idle: begin
                if (issue_valid) begin
                    st_next.user_space = issue_user_space;
                    st_next.vaddr = issue_base_addr;
                    st_next.lo_word = issue_low_word_source_data;
                    st_next.hi_word = issue_rd_data;
                    st_next.exc_code = exc_none;
                    // Checks that need no translation are raised at issue
                    if (st_reg.ctrl[CTRL_XNP] || (issue_user_space &&
                        !st_reg.ctrl[CTRL_ENH_VIRT_ADDR])) begin
                        st_next.exc_code = exc_reserved_instr;
                    end else if (issue_user_space && !cop0_usable) begin
                        st_next.exc_code = exc_cop_unusable;
                    end else if (!st_reg.ctrl[CTRL_MISAL] &&
                        issue_base_addr[DW_LSB-1:0] != '0) begin
                        st_next.exc_code = exc_address_error;
                    end
                    if (st_next.exc_code != exc_none) begin
                        st_next.exc_valid = 1'b1;
                        st_next.last_exc = 1'b1;
                        sc_done = 1'b1;
                    end else begin
                        st_next.state = st_xlat;
                        st_next.xlat_req = 1'b1;
                    end
                end
            end
            st_xlat: begin
                if (xlat_ack) begin
                    st_next.xlat_req = 1'b0;
                    st_next.paddr = xlat_paddr;
                    case (xlat_fault)
                        fault_refill: st_next.exc_code = exc_tlb_refill;
                        fault_invalid: st_next.exc_code = exc_tlb_invalid;
                        fault_modified: st_next.exc_code = exc_tlb_modified;
                        default: begin
                            if (!seg_ok) begin
                                st_next.exc_code = exc_address_error;
                            end else if (watch_hit) begin
                                st_next.exc_code = exc_watch;
                            end else begin
                                st_next.exc_code = exc_none;
                            end
                        end
                    endcase
                    if (st_next.exc_code != exc_none) begin
                        st_next.state = st_idle;
                        st_next.exc_valid = 1'b1;
                        st_next.last_exc = 1'b1;
                        sc_done = 1'b1;
                    end else if (link_ok) begin
                        // Lock stays up over both words so no observer
                        // sees half a pair
                        st_next.state = st_wr_lo;
                        st_next.mem_req = 1'b1;
                        st_next.mem_lock = 1'b1;
                        st_next.mem_addr = xlat_paddr;
                        st_next.mem_wdata = st_reg.lo_word;
                    end else begin
                        st_next.state = st_idle;
                        st_next.wb_valid = 1'b1;
                        st_next.wb_result = RESULT_FAIL;
                        st_next.last_ok = 1'b0;
                        st_next.last_exc = 1'b0;
                        // Counters wrap silently
                        st_next.fail_cnt = st_reg.fail_cnt + 1'b1;
                        sc_done = 1'b1;
                    end
                end
            end
            st_wr_lo: begin
                // Second word follows with the lock still held
                if (mem_ack) begin
                    st_next.state = st_wr_hi;
                    st_next.mem_addr = st_reg.paddr + WORD_STEP;
                    st_next.mem_wdata = st_reg.hi_word;
                end
            end
            st_wr_hi: begin
                if (mem_ack) begin
                    st_next.state = st_idle;
                    st_next.mem_req = 1'b0;
                    st_next.mem_lock = 1'b0;
                    st_next.wb_valid = 1'b1;
                    st_next.wb_result = RESULT_OK;
                    st_next.last_ok = 1'b1;
                    st_next.last_exc = 1'b0;
                    st_next.succ_cnt = st_reg.succ_cnt + 1'b1;
                    sc_done = 1'b1;
                end
            end
            default: begin
                // Unused encodings drop any request and go idle
                st_next.state = st_idle;
                st_next.xlat_req = 1'b0;
                st_next.mem_req = 1'b0;
                st_next.mem_lock = 1'b0;
            end
        endcase

        // Ready in the result cycle, so issues may run back to back
        st_next.issue_ready = st_next.state == st_idle;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign issue_ready = st_reg.issue_ready;
    assign xlat_req = st_reg.xlat_req;
    assign xlat_vaddr = st_reg.vaddr;
    // User-space variant translates through the user mapping
    assign xlat_user_map = st_reg.user_space;
    assign mem_req = st_reg.mem_req;
    assign mem_lock = st_reg.mem_lock;
    assign mem_addr = st_reg.mem_addr;
    assign mem_wdata = st_reg.mem_wdata;
    assign wb_valid = st_reg.wb_valid;
    assign wb_result = st_reg.wb_result;
    assign exc_valid = st_reg.exc_valid;
    assign exc_code = st_reg.exc_code;

endmodule

/* rtl/psc_pkg.sv */
// Constants and types shared by the paired store-conditional block
package psc_pkg;

    localparam int unsigned ADDR_W = 32;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned CNT_W = 16;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [REG_ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [REG_ADDR_W-1:0] REG_LINKED_ADDR = 8'h08;
    localparam logic [REG_ADDR_W-1:0] REG_SUCC_CNT = 8'h0C;
    localparam logic [REG_ADDR_W-1:0] REG_FAIL_CNT = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CTRL_ULS = 0;
    localparam int unsigned CTRL_XNP = 1;
    localparam int unsigned CTRL_ENH_VIRT_ADDR = 2;
    localparam int unsigned CTRL_MISAL = 3;
    localparam int unsigned CTRL_NOCACHE = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

    // Status register fields
    localparam int unsigned STATUS_W = 4;
    localparam int unsigned ST_LINK = 0;
    localparam int unsigned ST_LAST_OK = 1;
    localparam int unsigned ST_BUSY = 2;
    localparam int unsigned ST_LAST_EXC = 3;

    // Address bits below one double word, and below one monitored block
    localparam int unsigned DW_LSB = 3;
    localparam int unsigned LINK_BLOCK_LSB = 3;
    localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
    localparam logic [WORD_W-1:0] RESULT_OK = 32'h0000_0001;
    localparam logic [WORD_W-1:0] RESULT_FAIL = 32'h0000_0000;

    typedef enum logic [2:0] {
        unmapped_kernel_mode,
        mapped_kernel_mode,
        mapped_user_super_kernel_mode,
        unmapped_user_super_kernel_mode,
        mapped_user_super_kernel_alt_mode,
        mapped_user_only_mode
    } psc_seg_mode_t;

    typedef enum logic [1:0] {
        fault_none,
        fault_refill,
        fault_invalid,
        fault_modified
    } psc_fault_t;

    typedef enum logic [2:0] {
        exc_none,
        exc_tlb_refill,
        exc_tlb_invalid,
        exc_tlb_modified,
        exc_reserved_instr,
        exc_address_error,
        exc_watch,
        exc_cop_unusable
    } psc_exc_t;

    typedef enum logic [2:0] {
        st_idle,
        st_xlat,
        st_wr_lo,
        st_wr_hi
    } psc_state_t;

endpackage

/* rtl/psc_link_monitor.sv */
// Link flag and linked address tracking for the conditional pair store
`timescale 1ns/1ps
module psc_link_monitor
    import psc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ll_valid,
    input wire logic [psc_pkg::ADDR_W-1:0] ll_paddr,
    input wire logic snoop_store_valid,
    input wire logic [psc_pkg::ADDR_W-1:0] snoop_paddr,
    input wire logic eret_exec,
    input wire logic exc_taken,
    input wire logic sc_done,
    output logic link_flag,
    output logic [psc_pkg::ADDR_W-1:0] linked_address
);
    import psc_pkg::*;

    typedef struct packed {
        logic link_flag;
        logic [ADDR_W-1:0] linked_address;
    } psc_mon_state_t;

    psc_mon_state_t st_reg;
    psc_mon_state_t st_next;
    logic snoop_hit;

    always_comb begin
        st_next = st_reg;
        snoop_hit = snoop_store_valid && st_reg.link_flag &&
            (snoop_paddr[ADDR_W-1:LINK_BLOCK_LSB] ==
             st_reg.linked_address[ADDR_W-1:LINK_BLOCK_LSB]);
        // Clears first, so a load-linked in the same cycle still wins
        if (snoop_hit || eret_exec) begin
            st_next.link_flag = 1'b0;
        end
        if (exc_taken) begin
            st_next.link_flag = 1'b0;
        end
        if (sc_done) begin
            st_next.link_flag = 1'b0;
        end
        // Any load-linked type arms the link; plain loads are not seen here
        if (ll_valid) begin
            st_next.link_flag = 1'b1;
            st_next.linked_address = ll_paddr;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link_flag = st_reg.link_flag;
    assign linked_address = st_reg.linked_address;

endmodule

/* verif/psc_sc_pair_asserts.sv */
// Port checker for the conditional pair store unit
`timescale 1ns/1ps
module psc_sc_pair_asserts
    import psc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [31:0] issue_base_addr,
    input wire logic [31:0] issue_low_word_source_data,
    input wire logic [31:0] issue_rd_data,
    input wire logic ll_valid,
    input wire logic [31:0] ll_paddr,
    input wire logic snoop_store_valid,
    input wire logic eret_exec,
    input wire logic exc_taken,
    input wire logic xlat_req,
    input wire logic [31:0] xlat_vaddr,
    input wire logic xlat_ack,
    input wire logic mem_req,
    input wire logic mem_lock,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic wb_valid,
    input wire logic [31:0] wb_result,
    input wire logic exc_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [31:0] lo_cap, hi_cap, ll_cap;
    logic armed, wseen;
    // Shadow link state; snoops are only sent to the linked block
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {lo_cap, hi_cap, ll_cap, armed, wseen} <= '0;
        end else begin
            if (issue_valid && issue_ready) begin
                lo_cap <= issue_low_word_source_data;
                hi_cap <= issue_rd_data;
            end
            if (ll_valid) begin
                ll_cap <= ll_paddr;
            end
            if (ll_valid) begin
                armed <= 1'b1;
            end else if (wb_valid || exc_valid || snoop_store_valid ||
                    eret_exec || exc_taken) begin
                armed <= 1'b0;
            end
            wseen <= mem_req && (wseen || mem_ack);
        end
    end
    AST_ISSUE_ADDR: assert property (issue_valid && issue_ready |=>
        !xlat_req || xlat_vaddr == $past(issue_base_addr))
        else $error("translation address is not the base register");
    AST_XLAT_HOLD: assert property (xlat_req && !xlat_ack |=>
        xlat_req && $stable(xlat_vaddr))
        else $error("translation request dropped or changed");
    AST_LOCKED: assert property (mem_req |-> mem_lock)
        else $error("word write outside the bus lock");
    AST_LOW_FIRST: assert property ($rose(mem_req) |->
        mem_wdata == lo_cap) else $error("first word is not the low word");
    AST_HIGH_NEXT: assert property (mem_req && mem_ack && !wseen |=>
        mem_req && mem_wdata == hi_cap && mem_addr == $past(mem_addr) + 4)
        else $error("second word wrong or not adjacent");
    AST_OK_RESULT: assert property (mem_req && mem_ack && wseen |=>
        !mem_req && wb_valid && wb_result == RESULT_OK)
        else $error("paired write did not end in success");
    AST_ONLY_LINKED: assert property ($rose(mem_req) |->
        armed && mem_addr[31:3] == ll_cap[31:3])
        else $error("write without a live matching link");
    AST_XLAT_ANSWER: assert property (xlat_req && xlat_ack |=>
        mem_req || wb_valid || exc_valid)
        else $error("no outcome one cycle after translation");
    AST_FAIL_NO_WRITE: assert property (exc_valid ||
        wb_valid && wb_result == RESULT_FAIL |-> !$past(mem_req))
        else $error("failed store had written memory");
endmodule

bind psc_store_cond_pair psc_sc_pair_asserts u_chk (
    .clk, .reset_n, .issue_valid, .issue_ready, .issue_base_addr,
    .issue_low_word_source_data, .issue_rd_data, .ll_valid, .ll_paddr,
    .snoop_store_valid, .eret_exec, .exc_taken, .xlat_req, .xlat_vaddr,
    .xlat_ack, .mem_req, .mem_lock, .mem_addr, .mem_wdata, .mem_ack,
    .wb_valid, .wb_result, .exc_valid
);

/* verif/psc_far_model.sv */
// Behavioural translator and memory port facing the pair store unit
`timescale 1ns/1ps
module psc_far_model
    import psc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [8:0] cfg,
    input wire logic xlat_req,
    input wire logic [31:0] xlat_vaddr,
    output logic xlat_ack,
    output logic [31:0] xlat_paddr,
    output logic xlat_cached,
    output psc_pkg::psc_fault_t xlat_fault,
    output psc_pkg::psc_seg_mode_t xlat_seg_mode,
    output logic watch_hit,
    input wire logic mem_req,
    output logic mem_ack
);
    logic [1:0] xcnt, mcnt;
    logic xwait, mwait;
    assign xwait = xlat_req && !xlat_ack;
    assign mwait = mem_req && !mem_ack;
    // One pulse per request after cfg[1:0] idle cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {xlat_ack, mem_ack, xcnt, mcnt} <= '0;
        end else begin
            xlat_ack <= xwait && xcnt == cfg[1:0];
            mem_ack <= mwait && mcnt == cfg[1:0];
            xcnt <= (xwait && xcnt != cfg[1:0]) ? xcnt + 2'h1 : 2'h0;
            mcnt <= (mwait && mcnt != cfg[1:0]) ? mcnt + 2'h1 : 2'h0;
        end
    end
    // Outside the answer the fields show junk, not the last answer
    assign xlat_paddr = xlat_ack ? xlat_vaddr ^ 32'h1000_0000 : ~xlat_vaddr;
    assign xlat_cached = xlat_ack ? !cfg[7] : cfg[7];
    assign xlat_fault = psc_fault_t'(xlat_ack ? cfg[3:2] : ~cfg[3:2]);
    assign xlat_seg_mode = psc_seg_mode_t'(xlat_ack ? cfg[6:4] : 3'h7);
    assign watch_hit = xlat_ack ? cfg[8] : !cfg[8];
endmodule

/* verif/psc_store_cond_pair_bench.sv */
// Directed test of the conditional pair store unit
`timescale 1ns/1ps
module psc_store_cond_pair_bench;
    import psc_pkg::*;
    localparam logic [31:0] VA = 32'h0000_1230;
    localparam logic [31:0] PA = VA ^ 32'h1000_0000;
    logic clk, reset_n, reg_wr, reg_rd, issue_valid, issue_user_space;
    logic cop0_usable, issue_ready, xlat_req, xlat_user_map, xlat_ack;
    logic xlat_cached, watch_hit, mem_req, mem_lock, mem_ack, wb_valid;
    logic exc_valid;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, issue_base_addr;
    logic [31:0] issue_low_word_source_data;
    logic [31:0] issue_rd_data, xlat_vaddr, xlat_paddr, mem_addr;
    logic [31:0] mem_wdata, wb_result, ev_addr;
    logic [3:0] ev;
    logic [8:0] fcfg;
    psc_fault_t xlat_fault;
    psc_seg_mode_t xlat_seg_mode;
    psc_exc_t exc_code;
    logic [63:0] wq[$];
    int bad_count = 0;
    int n_compared = 0;
    psc_store_cond_pair dut (.clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .issue_valid, .issue_user_space,
        .issue_base_addr, .issue_low_word_source_data, .issue_rd_data,
        .issue_ready, .cop0_usable, .ll_valid(ev[0]), .ll_paddr(ev_addr),
        .snoop_store_valid(ev[1]), .snoop_paddr(ev_addr),
        .eret_exec(ev[2]), .exc_taken(ev[3]), .xlat_req, .xlat_vaddr,
        .xlat_user_map, .xlat_ack, .xlat_paddr, .xlat_cached, .xlat_fault,
        .xlat_seg_mode, .watch_hit, .mem_req, .mem_lock, .mem_addr,
        .mem_wdata, .mem_ack, .wb_valid, .wb_result, .exc_valid, .exc_code);
    psc_far_model far (.clk, .reset_n, .cfg(fcfg), .xlat_req, .xlat_vaddr,
        .xlat_ack, .xlat_paddr, .xlat_cached, .xlat_fault, .xlat_seg_mode,
        .watch_hit, .mem_req, .mem_ack);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            wq.push_back({mem_addr, mem_wdata});
        end
    end
    task automatic check(input string what, input logic [63:0] seen,
            input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check("register", {32'h0, reg_rdata}, {32'h0, exp});
    endtask
    task automatic pulse(input logic [3:0] e, input logic [31:0] a);
        @(posedge clk);
        ev <= e;
        ev_addr <= a;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    // Link first, then any clearing event, then the store itself
    task automatic step(input logic [31:0] ctrl, input logic [8:0] c,
            input logic [3:0] e, input logic [31:0] va, input logic usr,
            input psc_exc_t code, input logic ok);
        int i;
        reg_write(REG_CTRL, ctrl);
        fcfg <= c;
        if (e[0]) pulse(4'h1, PA);
        if (e[3:1] != 3'h0) pulse({e[3:1], 1'b0}, PA + 32'h4);
        wq.delete();
        @(posedge clk);
        issue_valid <= 1'b1;
        issue_user_space <= usr;
        issue_base_addr <= va;
        issue_low_word_source_data <= issue_low_word_source_data + 32'h1;
        issue_rd_data <= issue_rd_data - 32'h1;
        @(posedge clk);
        issue_valid <= 1'b0;
        i = 0;
        while (i < 40 && wb_valid !== 1'b1 && exc_valid !== 1'b1) begin
            @(negedge clk);
            i++;
        end
        if (i == 40) begin
            bad_count++;
            final_report();
        end
        check("kind", {62'h0, wb_valid, exc_valid},
            {62'h0, code == exc_none, code != exc_none});
        if (code != exc_none) begin
            check("code", {61'h0, exc_code}, {61'h0, code});
        end else begin
            check("result", {32'h0, wb_result}, {63'h0, ok});
        end
        check("user map", {63'h0, xlat_user_map}, {63'h0, usr});
        check("writes", 64'(wq.size()),
            64'((ok && code == exc_none) ? 2 : 0));
        if (wq.size() == 2) begin
            check("low word", wq[0],
                {va ^ 32'h1000_0000, issue_low_word_source_data});
            check("high word", wq[1],
                {(va ^ 32'h1000_0000) + 32'h4, issue_rd_data});
        end
    endtask
    initial begin
        {reset_n, reg_wr, reg_rd, issue_valid, issue_user_space, ev} = '0;
        {reg_addr, reg_wdata, issue_base_addr, ev_addr} = '0;
        {issue_low_word_source_data, issue_rd_data} = '0;
        cop0_usable = 1'b1;
        fcfg = 9'h020;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        reg_check(REG_CTRL, 32'h4);
        reg_check(8'h14, 32'h0);
        reg_write(REG_STATUS, 32'hF);
        reg_check(REG_STATUS, 32'h0);
        $display("test registers done");
        step(32'h4, 9'h020, 4'h1, VA, 1'b0, exc_none, 1'b1);
        step(32'h4, 9'h020, 4'h0, VA, 1'b0, exc_none, 1'b0);
        step(32'h4, 9'h020, 4'h1, VA + 32'h8, 1'b0, exc_none, 1'b0);
        step(32'h4, 9'h020, 4'h3, VA, 1'b0, exc_none, 1'b0);
        step(32'h4, 9'h020, 4'h5, VA, 1'b0, exc_none, 1'b0);
        step(32'h4, 9'h020, 4'h9, VA, 1'b0, exc_none, 1'b0);
        reg_check(REG_STATUS, 32'h0);
        reg_check(REG_SUCC_CNT, 32'h1);
        reg_check(REG_FAIL_CNT, 32'h5);
        reg_check(REG_LINKED_ADDR, PA);
        $display("test link done");
        step(32'h4, 9'h0A0, 4'h1, VA, 1'b0, exc_none, 1'b0);
        step(32'h5, 9'h0A0, 4'h1, VA, 1'b0, exc_none, 1'b1);
        step(32'h14, 9'h0A0, 4'h1, VA, 1'b0, exc_none, 1'b1);
        step(32'h4, 9'h020, 4'h1, VA, 1'b1, exc_none, 1'b1);
        step(32'h4, 9'h030, 4'h1, VA, 1'b1, exc_none, 1'b1);
        step(32'h4, 9'h040, 4'h1, VA, 1'b1, exc_none, 1'b1);
        step(32'hC, 9'h020, 4'h1, VA + 32'h4, 1'b0, exc_none, 1'b1);
        step(32'h4, 9'h023, 4'h1, VA, 1'b0, exc_none, 1'b1);
        $display("test success paths done");
        step(32'h4, 9'h024, 4'h1, VA, 1'b0, exc_tlb_refill, 1'b0);
        step(32'h4, 9'h028, 4'h1, VA, 1'b0, exc_tlb_invalid, 1'b0);
        step(32'h4, 9'h02C, 4'h1, VA, 1'b0, exc_tlb_modified, 1'b0);
        step(32'h4, 9'h120, 4'h1, VA, 1'b0, exc_watch, 1'b0);
        step(32'h6, 9'h020, 4'h1, VA, 1'b0, exc_reserved_instr, 1'b0);
        step(32'h0, 9'h020, 4'h1, VA, 1'b1, exc_reserved_instr, 1'b0);
        step(32'h4, 9'h020, 4'h1, VA + 32'h4, 1'b0, exc_address_error,
            1'b0);
        step(32'h4, 9'h000, 4'h1, VA, 1'b1, exc_address_error, 1'b0);
        @(posedge clk);
        cop0_usable <= 1'b0;
        step(32'h4, 9'h020, 4'h1, VA, 1'b1, exc_cop_unusable, 1'b0);
        $display("test exceptions done");
        final_report();
    end
endmodule
